// ==== core/gpx_pkg.sv ====
// Purpose : Shared constants for the GPIO pin crossbar block.
// Assumes : One 8-pin port, six digital and two analog pin users.
// Notes   : Index 0 of every peripheral vector has the highest priority.
package gpx_pkg;
   localparam int NUM_PINS = 8;
   localparam int NUM_DIG  = 6;

   // ************************************************************
   // Register map (byte offsets)
   // ************************************************************
   localparam logic [7:0] OFS_DATA   = 8'h00;
   localparam logic [7:0] OFS_DIR    = 8'h04;
   localparam logic [7:0] OFS_FEAT   = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // ************************************************************
   // Feature and status register fields and codes
   // ************************************************************
   localparam int FEAT_ADDR_LSB = 0;
   localparam int FEAT_GRP_BIT  = 3;
   localparam int FEAT_CODE_LSB = 4;
   localparam int STAT_ANA_LSB  = 8;
   localparam logic [2:0] FC_OUT_NORM = 3'h0;
   localparam logic [2:0] FC_OUT_HIGH = 3'h1;
   localparam logic [2:0] FC_IN_NOPULL = 3'h2;
   localparam logic [2:0] FC_IN_PULLUP = 3'h3;
   localparam logic [2:0] FC_IN_PULLDN = 3'h4;
   localparam logic [2:0] FC_IN_OFF    = 3'h5;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR  = 8'h00;
   localparam logic [2:0] RST_OUT_FEAT = FC_OUT_NORM;
   localparam logic [2:0] RST_IN_FEAT  = FC_IN_NOPULL;

   // ************************************************************
   // Pin map: {pwm, two_wire, debug, spi_slave, spi_master, lf_osc}
   // ************************************************************
   localparam logic [NUM_DIG-1:0][7:0] DIG_PIN_MASK =
      {8'h48, 8'h60, 8'h7C, 8'h3C, 8'h1C, 8'h02};
   localparam logic [NUM_DIG-1:0][7:0] DIG_OUT_MASK =
      {8'h48, 8'h00, 8'h60, 8'h10, 8'h0C, 8'h00};
   localparam logic [NUM_DIG-1:0][7:0] DIG_IO_MASK =
      {8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] ANA_CAP_MASK = 8'h7F;
   localparam int TX_PIN   = 5;
   localparam int RX_PIN   = 6;
   localparam int REF0_PIN = 0;
   localparam int REF1_PIN = 6;
   localparam int LF_DIG   = 0;

   // ************************************************************
   // Low-frequency oscillator pin modes
   // ************************************************************
   localparam logic [2:0] LF_XTAL    = 3'h0;
   localparam logic [2:0] LF_ANA_CLK = 3'h3;
   localparam logic [2:0] LF_DIG_CLK = 3'h4;
   localparam logic [7:0] LF_XTAL_PINS = 8'h03;
   localparam logic [7:0] LF_ANA_PINS  = 8'h02;
endpackage : gpx_pkg

// ==== core/gpx_pin_crossbar.sv ====
// Purpose : GPIO registers, peripheral pin router and pad control.
// Assumes : Peripheral enables come from logic on i_clk; pads do not.
// Notes   : AHB-Lite slave, zero wait states, always OKAY.
`timescale 1ns/10ps
`default_nettype none

module gpx_pin_crossbar
   import gpx_pkg::*;
(
   input  wire logic                      i_clk,         // System clock
   input  wire logic                      i_rst,         // Sync reset
   input  wire logic                      i_hsel,        // Slave select
   input  wire logic [31:0]               i_haddr,       // Byte address
   input  wire logic [1:0]                i_htrans,      // Transfer type
   input  wire logic                      i_hwrite,      // Write access
   input  wire logic [2:0]                i_hsize,       // Access size
   input  wire logic [31:0]               i_hwdata,      // Write data
   input  wire logic                      i_hready,      // Bus ready
   output logic [31:0]                    o_hrdata,      // Read data
   output logic                           o_hreadyout,   // Slave ready
   output logic                           o_hresp,       // Response
   input  wire logic [gpx_pkg::NUM_PINS-1:0] i_pad_in,   // Pad levels
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_out,     // Pad drive value
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_oe_n,    // Drive enable, low
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_hidrive, // High drive
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_pullup,  // Pull-up on
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_pulldn,  // Pull-down on
   output logic [gpx_pkg::NUM_PINS-1:0]   o_pad_inbuf,   // Input buffer on
   input  wire logic [gpx_pkg::NUM_DIG-1:0] i_dig_en,    // Peripheral enables
   input  wire logic [gpx_pkg::NUM_DIG*8-1:0] i_dig_out, // Peripheral outputs
   input  wire logic [gpx_pkg::NUM_DIG*8-1:0] i_dig_oe,  // Inout drive wish
   output logic [gpx_pkg::NUM_DIG*8-1:0]  o_dig_in,      // Peripheral inputs
   output logic [gpx_pkg::NUM_DIG-1:0]    o_dig_grant,   // Granted users
   input  wire logic                      i_uart_txd,    // Serial transmit
   output logic                           o_uart_rxd,    // Serial receive
   input  wire logic                      i_lf_en,       // Osc enable
   input  wire logic [2:0]                i_lf_mode,     // Osc pin mode
   input  wire logic                      i_conv_en,     // Converter enable
   input  wire logic                      i_comp_en,     // Comparator enable
   input  wire logic [2:0]                i_conv_chsel,  // Channel select
   input  wire logic [1:0]                i_conv_refsel, // Reference select
   output logic [gpx_pkg::NUM_PINS-1:0]   o_ana_lf,      // Osc analog switch
   output logic [gpx_pkg::NUM_PINS-1:0]   o_ana_conv     // Converter switch
);
   import gpx_pkg::*;

   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0]            data_r;
   logic [7:0]            dir_r;
   logic [NUM_PINS-1:0][2:0] out_feat_r;
   logic [NUM_PINS-1:0][2:0] in_feat_r;
   logic [2:0]            feat_addr_r;
   logic                  feat_grp_r;
   logic [7:0]            pad_s1_r;
   logic [7:0]            pad_s2_r;
   logic [7:0]            owned_r;
   logic                  wr_pend_r;
   logic [7:0]            wr_ofs_r;

   // ************************************************************
   // Grant and pin decode
   // ************************************************************
   logic [NUM_DIG-1:0]    dig_req;
   logic [NUM_DIG-1:0]    grant_c;
   logic [7:0]            own_c;
   logic [7:0]            dout_c;
   logic [7:0]            doe_c;
   logic [7:0]            lf_pins_c;
   logic [7:0]            conv_pins_c;

   // Overlap between two pin masks
   function automatic logic f_ovl(input logic [7:0] a, input logic [7:0] b);
      f_ovl = |(a & b);
   endfunction : f_ovl

   // Feature of one pin for one group
   function automatic logic [2:0] f_feat(input logic [2:0] idx,
                                         input logic       grp,
                                         input logic [NUM_PINS-1:0][2:0] o,
                                         input logic [NUM_PINS-1:0][2:0] i);
      f_feat = grp ? o[idx] : i[idx];
   endfunction : f_feat

   // Oscillator digital clock mode counts as a digital request
   always_comb begin
      dig_req = i_dig_en;
      dig_req[LF_DIG] = i_lf_en && (i_lf_mode == LF_DIG_CLK);
   end

   // Priority resolution, whole request or nothing
   genvar gk;
   generate
      for (gk = 0; gk < NUM_DIG; gk++) begin : g_grant
         always_comb begin
            grant_c[gk] = dig_req[gk];
            for (int h = 0; h < gk; h++) begin
               if (dig_req[h] && f_ovl(DIG_PIN_MASK[h], DIG_PIN_MASK[gk]))
                  grant_c[gk] = 1'b0;
            end
         end
      end
   endgenerate

   // Pin ownership and drive from granted users
   always_comb begin
      own_c  = 8'h00;
      dout_c = 8'h00;
      doe_c  = 8'h00;
      for (int k = 0; k < NUM_DIG; k++) begin
         if (grant_c[k]) begin
            own_c  = own_c | DIG_PIN_MASK[k];
            dout_c = dout_c | (i_dig_out[k*8 +: 8] & DIG_PIN_MASK[k]);
            doe_c  = doe_c | DIG_OUT_MASK[k]
                   | (DIG_IO_MASK[k] & i_dig_oe[k*8 +: 8]);
         end
      end
   end

   // Analog requests, oscillator before converter
   always_comb begin
      lf_pins_c   = 8'h00;
      conv_pins_c = 8'h00;
      if (i_lf_en && i_lf_mode == LF_XTAL)
         lf_pins_c = LF_XTAL_PINS;
      else if (i_lf_en && i_lf_mode == LF_ANA_CLK)
         lf_pins_c = LF_ANA_PINS;
      if (i_conv_en || i_comp_en) begin
         conv_pins_c = 8'h01 << i_conv_chsel;
         if (i_conv_refsel == 2'h1)
            conv_pins_c[REF0_PIN] = 1'b1;
         else if (i_conv_refsel == 2'h2)
            conv_pins_c[REF1_PIN] = 1'b1;
      end
      conv_pins_c = conv_pins_c & ANA_CAP_MASK & ~lf_pins_c;
   end

   // ************************************************************
   // Pad synchroniser
   // ************************************************************
   // Two stages before any pad level is used
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pad_s1_r <= 8'h00;
         pad_s2_r <= 8'h00;
      end else begin
         pad_s1_r <= i_pad_in;
         pad_s2_r <= pad_s1_r;
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   logic       aphase;
   logic [7:0] aofs;
   logic [2:0] wr_addr;
   logic       wr_grp;
   logic [2:0] wr_code;
   assign aphase  = i_hsel && i_htrans[1] && i_hready;
   assign aofs    = i_haddr[7:0];
   assign wr_addr = i_hwdata[FEAT_ADDR_LSB +: 3];
   assign wr_grp  = i_hwdata[FEAT_GRP_BIT];
   assign wr_code = i_hwdata[FEAT_CODE_LSB +: 3];

   // Address phase capture, read data ready for the data phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_pend_r   <= 1'b0;
         wr_ofs_r    <= 8'h00;
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         wr_pend_r   <= aphase && i_hwrite && (i_haddr[31:8] == 24'h000000);
         wr_ofs_r    <= aofs;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= 32'h0000_0000;
         if (aphase && !i_hwrite && i_haddr[31:8] == 24'h000000) begin
            unique case (aofs)
               OFS_DATA:   o_hrdata <= {24'h000000, pad_s2_r};
               OFS_DIR:    o_hrdata <= {24'h000000, dir_r};
               OFS_FEAT:   o_hrdata <= {25'h0,
                              f_feat(feat_addr_r, feat_grp_r,
                                     out_feat_r, in_feat_r),
                              feat_grp_r, feat_addr_r};
               OFS_STATUS: o_hrdata <= {16'h0000, own_c,
                              2'h0, grant_c};
               default:    o_hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Whole-port data and direction writes
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         data_r <= RST_DATA;
         dir_r  <= RST_DIR;
      end else if (wr_pend_r) begin
         if (wr_ofs_r == OFS_DATA)
            data_r <= i_hwdata[7:0];
         if (wr_ofs_r == OFS_DIR)
            dir_r <= i_hwdata[7:0];
      end
   end

   // One pin per feature write; mismatched group and code ignored
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         feat_addr_r <= 3'h0;
         feat_grp_r  <= 1'b0;
         for (int p = 0; p < NUM_PINS; p++) begin
            out_feat_r[p] <= RST_OUT_FEAT;
            in_feat_r[p]  <= RST_IN_FEAT;
         end
      end else if (wr_pend_r && wr_ofs_r == OFS_FEAT) begin
         feat_addr_r <= wr_addr;
         feat_grp_r  <= wr_grp;
         if (wr_grp && wr_code <= FC_OUT_HIGH)
            out_feat_r[wr_addr] <= wr_code;
         else if (!wr_grp && wr_code >= FC_IN_NOPULL
                  && wr_code <= FC_IN_OFF)
            in_feat_r[wr_addr] <= wr_code;
      end
   end

   // ************************************************************
   // Pad control
   // ************************************************************
   logic [7:0] out_nxt;
   logic [7:0] oe_n_nxt;
   logic [7:0] hid_nxt;
   logic [7:0] pu_nxt;
   logic [7:0] pd_nxt;
   logic [7:0] ib_nxt;

   // Owner picks pad settings; analog use changes none of them
   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         if (own_c[p]) begin
            out_nxt[p]  = dout_c[p];
            oe_n_nxt[p] = !doe_c[p];
            hid_nxt[p]  = 1'b0;
            pu_nxt[p]   = 1'b0;
            pd_nxt[p]   = 1'b0;
            ib_nxt[p]   = 1'b1;
         end else begin
            out_nxt[p]  = data_r[p];
            oe_n_nxt[p] = !dir_r[p];
            hid_nxt[p]  = dir_r[p] && out_feat_r[p] == FC_OUT_HIGH;
            pu_nxt[p]   = !dir_r[p] && in_feat_r[p] == FC_IN_PULLUP;
            pd_nxt[p]   = !dir_r[p] && in_feat_r[p] == FC_IN_PULLDN;
            ib_nxt[p]   = in_feat_r[p] != FC_IN_OFF;
         end
      end
      if (!own_c[TX_PIN])
         out_nxt[TX_PIN] = data_r[TX_PIN] & i_uart_txd;
   end

   // Registered pad and analog switch outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pad_out     <= 8'h00;
         o_pad_oe_n    <= 8'hFF;
         o_pad_hidrive <= 8'h00;
         o_pad_pullup  <= 8'h00;
         o_pad_pulldn  <= 8'h00;
         o_pad_inbuf   <= 8'hFF;
         o_ana_lf      <= 8'h00;
         o_ana_conv    <= 8'h00;
         owned_r       <= 8'h00;
      end else begin
         o_pad_out     <= out_nxt;
         o_pad_oe_n    <= oe_n_nxt;
         o_pad_hidrive <= hid_nxt;
         o_pad_pullup  <= pu_nxt;
         o_pad_pulldn  <= pd_nxt;
         o_pad_inbuf   <= ib_nxt;
         o_ana_lf      <= lf_pins_c;
         o_ana_conv    <= conv_pins_c;
         owned_r       <= own_c;
      end
   end

   // Inputs to peripherals and serial receiver
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dig_in    <= '0;
         o_dig_grant <= '0;
         o_uart_rxd  <= 1'b1;
      end else begin
         o_dig_grant <= grant_c;
         for (int k = 0; k < NUM_DIG; k++)
            o_dig_in[k*8 +: 8] <= grant_c[k] ?
               (pad_s2_r & DIG_PIN_MASK[k] & ~DIG_OUT_MASK[k]) : 8'h00;
         o_uart_rxd <= (!own_c[RX_PIN] && !dir_r[RX_PIN]) ?
                       pad_s2_r[RX_PIN] : 1'b1;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   AST_RESET_INPUT: assert property (@(posedge i_clk)
      $past(i_rst) |-> (o_pad_oe_n == 8'hFF && o_pad_inbuf == 8'hFF))
      else $error("pins not inputs after reset");

   AST_SLAVE_LOSES: assert property (@(posedge i_clk)
      disable iff (i_rst) (i_dig_en[1] && i_dig_en[2]) |=> !o_dig_grant[2])
      else $error("lower priority peripheral granted");

   AST_ALL_PINS: assert property (@(posedge i_clk)
      disable iff (i_rst) o_dig_grant[3] |-> ((owned_r & DIG_PIN_MASK[3])
      == DIG_PIN_MASK[3])) else $error("partial grant");

   AST_GPIO_DRIVE: assert property (@(posedge i_clk)
      disable iff (i_rst) (dir_r[0] && !own_c[0]) |=> (!o_pad_oe_n[0] &&
                                   o_pad_out[0] == $past(data_r[0])))
      else $error("gpio output not driven");

   AST_TX_AND: assert property (@(posedge i_clk)
      disable iff (i_rst) (!own_c[TX_PIN] && dir_r[TX_PIN]) |=>
      o_pad_out[TX_PIN] == ($past(data_r[TX_PIN]) & $past(i_uart_txd)))
      else $error("transmit merge wrong");

   AST_ANA_IDLE: assert property (@(posedge i_clk)
      disable iff (i_rst) !(i_conv_en || i_comp_en) |=> o_ana_conv == 8'h00)
      else $error("converter pins without request");

   AST_ANA_PRIO: assert property (@(posedge i_clk)
      disable iff (i_rst) (o_ana_conv & o_ana_lf) == 8'h00)
      else $error("analog pin shared");

   AST_DIR_WRITE: assert property (@(posedge i_clk)
      disable iff (i_rst) (aphase && i_hwrite && aofs == OFS_DIR
      && i_haddr[31:8] == 24'h0) ##1 1'b1 |=> dir_r == $past(i_hwdata[7:0]))
      else $error("direction write lost");

   AST_FEAT_WRITE: assert property (@(posedge i_clk)
      disable iff (i_rst) (wr_pend_r && wr_ofs_r == OFS_FEAT && wr_grp
       && wr_code == FC_OUT_HIGH) |=> out_feat_r[$past(wr_addr)]
       == FC_OUT_HIGH)
      else $error("feature write lost");
endmodule : gpx_pin_crossbar

`default_nettype wire

// ==== tb/gpx_pad_model.sv ====
// Purpose : Board model of the eight pads around the pin crossbar.
// Assumes : The board drives only pins that the block leaves undriven.
// Notes   : A floating pin toggles each cycle, so it never reads stable.
`timescale 1ns/10ps
`default_nettype none
module gpx_pad_model (
   input  wire logic       i_clk,     // System clock
   input  wire logic [7:0] i_out,     // Block drive value
   input  wire logic [7:0] i_oe_n,    // Block drive enable, low
   input  wire logic [7:0] i_pullup,  // Pull-up on
   input  wire logic [7:0] i_pulldn,  // Pull-down on
   input  wire logic [7:0] i_ext_en,  // Board driver enable
   input  wire logic [7:0] i_ext_val, // Board driver value
   output logic [7:0]      o_pad      // Resolved pad level
);
   logic [7:0] float_r = 8'h55;
   // ****************
   // Pad resolution
   // ****************
   // Floating level wanders
   always_ff @(posedge i_clk) begin
      float_r <= ~float_r;
   end
   // Block drive, then board drive, then pulls, then float
   assign o_pad = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext_val)
                | (i_oe_n & ~i_ext_en & (i_pullup | (~i_pulldn & float_r)));
endmodule : gpx_pad_model
`default_nettype wire

// ==== tb/gpx_pin_crossbar_tb.sv ====
// Purpose : Self-checking bench for the GPIO pin crossbar.
// Assumes : Zero-wait AHB-Lite slave, pad outputs one edge after change.
// Notes   : Grant expectations are worked out from the package pin map.
`timescale 1ns/10ps
`default_nettype none
module gpx_pin_crossbar_tb;
   import gpx_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0, refsel = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp, txd = 1'b1, rxd;
   logic        lf_en = 1'b0, conv_en = 1'b0, comp_en = 1'b0;
   logic [2:0]  lf_mode = 3'h0, chsel = 3'h0;
   logic [7:0]  pad_in, pad_out, oe_n, hid, pu, pd, ib, ana_lf, ana_conv;
   logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
   logic [5:0]  dig_en = 6'h00, grant;
   logic [47:0] dig_out = 48'h0, dig_oe = 48'h0, dig_in;
   int          err_total = 0, n_tests = 0;
   // ****************
   // Clock, design and pads
   // ****************
   always #50 clk = ~clk;
   gpx_pin_crossbar DUT (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
      .o_pad_hidrive(hid), .o_pad_pullup(pu), .o_pad_pulldn(pd),
      .o_pad_inbuf(ib), .i_dig_en(dig_en), .i_dig_out(dig_out),
      .i_dig_oe(dig_oe), .o_dig_in(dig_in), .o_dig_grant(grant),
      .i_uart_txd(txd), .o_uart_rxd(rxd), .i_lf_en(lf_en),
      .i_lf_mode(lf_mode), .i_conv_en(conv_en), .i_comp_en(comp_en),
      .i_conv_chsel(chsel), .i_conv_refsel(refsel), .o_ana_lf(ana_lf),
      .o_ana_conv(ana_conv));
   gpx_pad_model PADS (.i_clk(clk), .i_out(pad_out), .i_oe_n(oe_n),
      .i_pullup(pu), .i_pulldn(pd), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_pad(pad_in));
   // ****************
   // Tasks
   // ****************
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One AHB-Lite single transfer, waits on ready
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      chk(rd, exp);
   endtask : rd_chk
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Users 1 to 5: enabled and no enabled higher user shares a pin; user 0 is never expected granted
   function automatic logic [5:0] exp_grant(input logic [5:0] en);
      logic [5:0] g;
      g = 6'h00;
      for (int k = 1; k < NUM_DIG; k++) begin
         g[k] = en[k];
         for (int j = 1; j < k; j++)
            if (en[j] && (DIG_PIN_MASK[j] & DIG_PIN_MASK[k]) != 8'h00)
               g[k] = 1'b0;
      end
      return g;
   endfunction : exp_grant
   // Apply enables, check grants and owned pins
   task xbar(input logic [5:0] en);
      logic [5:0] g;
      logic [7:0] own;
      g = exp_grant(en);
      own = 8'h00;
      for (int k = 0; k < NUM_DIG; k++)
         if (g[k])
            own = own | DIG_PIN_MASK[k];
      dig_en <= en;
      tick(2);
      chk({26'h0, grant}, {26'h0, g});
      rd_chk(OFS_STATUS, {16'h0, own, 2'h0, g});
   endtask : xbar
   // Analog request, pads must stay as they were
   task ana(input logic ce, cm, le, input logic [2:0] lm, ch,
            input logic [1:0] rs, input logic [15:0] exp);
      conv_en <= ce;
      comp_en <= cm;
      lf_en <= le;
      lf_mode <= lm;
      chsel <= ch;
      refsel <= rs;
      tick(2);
      chk({ib, oe_n, ana_lf, ana_conv}, {8'h77, 8'hD0, exp});
   endtask : ana
   task end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // ****************
   // Watchdog and tests
   // ****************
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({oe_n, ib, pu, pd}, 32'hFFFF0000);
      chk({7'h0, rxd, hid, 2'h0, grant, ana_lf | ana_conv},
          32'h01000000);
      rd_chk(OFS_DIR, 32'h0);
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      rd_chk(8'h10, 32'h0);
      ext_en <= 8'hF0;
      ext_val <= 8'hA0;
      bus(1'b1, OFS_DIR, 32'h0F);
      bus(1'b1, OFS_DATA, 32'hA5);
      tick(4);
      chk({20'h0, oe_n, pad_out[3:0]}, 32'hF05);
      rd_chk(OFS_DIR, 32'h0F);
      rd_chk(OFS_DATA, 32'hA5);
      bus(1'b1, OFS_DIR, 32'h2F);
      txd <= 1'b0;
      tick(2);
      chk({31'h0, pad_out[5]}, 32'h0);
      txd <= 1'b1;
      ext_val <= 8'h20;
      tick(5);
      chk({30'h0, pad_out[5], rxd}, 32'h2);
      ext_val <= 8'hF0;
      tick(5);
      chk({31'h0, rxd}, 32'h1);
      for (int c = 2; c <= 5; c++) begin
         bus(1'b1, OFS_FEAT, {25'h0, c[2:0], 4'h7});
         tick(2);
         chk({29'h0, pu[7], pd[7], ib[7]},
             {29'h0, c == 3, c == 4, c != 5});
         rd_chk(OFS_FEAT, {25'h0, c[2:0], 4'h7});
      end
      bus(1'b1, OFS_FEAT, 32'h7F);
      rd_chk(OFS_FEAT, 32'h0F);
      bus(1'b1, OFS_FEAT, 32'h18);
      tick(2);
      chk({31'h0, hid[0]}, 32'h1);
      rd_chk(OFS_FEAT, 32'h18);
      dig_out <= {8'h0, 8'h40, 16'h0, 8'h0C, 8'h00};
      dig_oe <= {8'h0, 8'h40, 32'h0};
      xbar(6'b111110);
      tick(3);
      chk({29'h0, pad_out[3:2], dig_in[12]}, 32'h7);
      xbar(6'b110000);
      chk({16'h0, oe_n, pad_out}, 32'h0000B0C5);
      xbar(6'b100000);
      xbar(6'b101000);
      xbar(6'b000000);
      chk({29'h0, pad_out[3:2], dig_in[12]}, 32'h2);
      bus(1'b1, OFS_FEAT, 32'h53);
      ana(1'b1, 1'b0, 1'b0, LF_XTAL, 3'h3, 2'h1,
          16'h0009);
      ana(1'b0, 1'b1, 1'b0, LF_XTAL, 3'h4, 2'h2,
          16'h0050);
      ana(1'b1, 1'b0, 1'b0, LF_XTAL, 3'h7, 2'h0,
          16'h0000);
      ana(1'b1, 1'b0, 1'b1, LF_XTAL, 3'h1, 2'h1,
          {LF_XTAL_PINS, 8'h00});
      ana(1'b1, 1'b0, 1'b1, LF_ANA_CLK, 3'h0, 2'h0,
          {LF_ANA_PINS, 8'h01});
      conv_en <= 1'b0;
      lf_mode <= LF_DIG_CLK;
      tick(2);
      chk({8'h0, oe_n, ana_lf, 2'h0, grant}, 32'h00D20001);
      end_sim;
   end
endmodule : gpx_pin_crossbar_tb
`default_nettype wire
